// File: pld_macrocell_array.sv
// Macrocell array with two flops per cell, APB fuse and config access
//
// Functional notes
// R01: Each flop is separately configured as D or T type.
// R02: Bypass routes buried next state, not stored value, to feedback.
// R03: Each flop has own clock term; pin clock or term selectable.
// R04: Two flops per cell, 48 total, each own clock, clear, sum.
// R05: Each pin has own input path; each enable from own term.
// R06: Three sum terms combine into one of twelve terms, no lag.
// R07: Enabled keepers hold undriven pins at last driven level.
// R08: Keepers are off after reset until software enables them.
// R09: A 64-bit user row is kept apart from the logic config.
// R10: Reset clears every flop low; outputs follow polarity.
// R11: Outside logic keeps clock sources still during reset.
// R12: Outside logic holds clocks low until setup is met after reset.
// R13: Force load sets each flop from its pin, ignoring config.
// R14: Each strobe pulse in force load loads one group of 12.
// R15: Two selects pick even/odd cells and main/buried flops.
// R16: Observe mode drives buried flops out when enables are active.
// R17: Security fuse at once disables force load and observe.
// R18: With security set every fuse location reads as programmed.
// R19: 24 cells, 17 product terms each, 172 bus inputs per term.
// R20: Five terms give clears, clocks, enable; twelve feed sums.
// R21: Eight presets shared by cells in groups of four then two.
// R22: Bus holds 14 inputs and three signals per cell, both senses.
// R23: Clear acts at once; preset only at the next clock edge.
//
// The implementer's own choices: the APB slave port and the register offsets.
module pld_macrocell_array #(
  parameter int ADDR_W = 16
) (
  input wire logic SYS_CLK, // System clock, 10 MHz
  input wire logic SYS_RST, // Synchronous reset, high
  input wire logic [ADDR_W-1:0] PADDR, // APB byte address
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB access phase
  input wire logic PWRITE, // APB write
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error, unmapped
  input wire logic [pld_pkg::NUM_DED-1:0] DED_IN, // Dedicated inputs
  input wire logic [pld_pkg::NUM_DED-1:0] DED_DRIVEN, // Driven by board
  input wire logic [pld_pkg::NUM_MC-1:0] IO_IN, // Pin levels seen
  input wire logic [pld_pkg::NUM_MC-1:0] IO_DRIVEN, // Driven by board
  output logic [pld_pkg::NUM_MC-1:0] IO_OUT, // Pin drive value
  output logic [pld_pkg::NUM_MC-1:0] IO_OE, // Pin drive enable
  input wire logic FORCE_LOAD_MODE, // Test preload mode
  input wire logic LOAD_STROBE, // Preload strobe
  input wire logic Q_SELECT, // Main or buried group
  input wire logic EVEN_ODD_SELECT, // Even or odd cells
  input wire logic OBSERVE_MODE // Buried flop observe mode
);

  localparam int NMC = pld_pkg::NUM_MC;
  localparam int NDED = pld_pkg::NUM_DED;
  localparam int NT = pld_pkg::NUM_TERMS;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Preset index for a cell: 4,2,4,2... cells per preset
  function automatic int preset_of(input int m);
    int grp;
    grp = m / pld_pkg::PRESET_SPAN;
    return 2 * grp
      + ((m % pld_pkg::PRESET_SPAN) >= pld_pkg::PRESET_FIRST ? 1 : 0);
  endfunction : preset_of

  // Flat term index of slot k in cell m
  function automatic int term_of(input int m, input int k);
    return m * pld_pkg::TERMS_PER_MC + k;
  endfunction : term_of

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NMC-1:0] main_flop;
    logic [NMC-1:0] buried_flop;
    logic [NMC-1:0] buried_feedback;
    logic [NMC-1:0] main_ck_prev;
    logic [NMC-1:0] buried_ck_prev;
    logic [NMC-1:0] pin_lvl;
    logic [NDED-1:0] ded_lvl;
    logic [NMC-1:0] io_out;
    logic [NMC-1:0] io_oe;
    logic [NMC-1:0][pld_pkg::CFG_W-1:0] cfg;
    logic strobe_prev;
    logic keeper_en;
    logic secure;
    logic [pld_pkg::USER_ROW_W-1:0] user_row;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  // Fuse rows: one per product term, a set bit connects a bus input
  logic [pld_pkg::FUSE_ROW_W-1:0] fuse_mem [NT];
  logic [pld_pkg::BUS_W-1:0] gbus;
  logic [NT-1:0] term;
  logic fuse_we;
  logic [8:0] fuse_t;
  logic [2:0] fuse_w;
  logic fuse_hit;
  logic acc_done;

  // ----------------------------------------------------------------
  // Global bus and product terms
  // ----------------------------------------------------------------
  // Bus is built from registered state only, so bypassed feedback
  // cannot close a combinational loop through the array.
  // R22 bus layout
  always_comb begin
    gbus = '0;
    for (int i = 0; i < NDED; i++) begin
      gbus[2*i] = s_r.ded_lvl[i];
      gbus[2*i+1] = ~s_r.ded_lvl[i];
    end
    for (int m = 0; m < NMC; m++) begin
      gbus[pld_pkg::BUS_MC_BASE+pld_pkg::MC_BUS_W*m] =
        s_r.buried_feedback[m];
      gbus[pld_pkg::BUS_MC_BASE+pld_pkg::MC_BUS_W*m+1] =
        ~s_r.buried_feedback[m];
      gbus[pld_pkg::BUS_MC_BASE+pld_pkg::MC_BUS_W*m+2] =
        s_r.main_flop[m];
      gbus[pld_pkg::BUS_MC_BASE+pld_pkg::MC_BUS_W*m+3] =
        ~s_r.main_flop[m];
      // R05 own pin path
      gbus[pld_pkg::BUS_MC_BASE+pld_pkg::MC_BUS_W*m+4] = s_r.pin_lvl[m];
      gbus[pld_pkg::BUS_MC_BASE+pld_pkg::MC_BUS_W*m+5] = ~s_r.pin_lvl[m];
    end
  end

  // R19 wide AND terms
  always_comb begin
    for (int t = 0; t < NT; t++) begin
      term[t] = &(gbus | ~fuse_mem[t][pld_pkg::BUS_W-1:0]);
    end
  end

  // ----------------------------------------------------------------
  // APB decode for the fuse rows
  // ----------------------------------------------------------------
  always_comb begin
    fuse_t = PADDR[13:5];
    fuse_w = PADDR[4:2];
    fuse_hit = (PADDR < pld_pkg::FUSE_LIMIT)
      && (int'(fuse_t) < NT) && (int'(fuse_w) < pld_pkg::FUSE_WORDS);
    acc_done = PSEL && PENABLE && s_r.pready;
    fuse_we = acc_done && PWRITE && fuse_hit;
  end

  // Fuse memory; kept outside the state record as it is an array
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      for (int t = 0; t < NT; t++) begin
        fuse_mem[t] <= '0;
      end
    end else if (fuse_we) begin
      fuse_mem[fuse_t][fuse_w*32 +: 32] <= PWDATA;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic sa;
    logic sb;
    logic sc;
    logic d1;
    logic d2;
    logic c1;
    logic c2;
    logic pre;
    logic load_pulse;
    logic [NMC-1:0] drv;
    int idx;
    sa = 1'b0;
    sb = 1'b0;
    sc = 1'b0;
    d1 = 1'b0;
    d2 = 1'b0;
    c1 = 1'b0;
    c2 = 1'b0;
    pre = 1'b0;
    load_pulse = 1'b0;
    drv = '0;
    idx = 0;
    s_nxt = s_r;

    // R07 keeper on dedicated inputs
    for (int i = 0; i < NDED; i++) begin
      if (DED_DRIVEN[i] || !s_r.keeper_en) begin
        s_nxt.ded_lvl[i] = DED_IN[i];
      end
    end
    // R07 keeper on I/O; own drive counts as driven
    drv = IO_DRIVEN | s_r.io_oe;
    for (int m = 0; m < NMC; m++) begin
      if (drv[m] || !s_r.keeper_en) begin
        s_nxt.pin_lvl[m] = IO_IN[m];
      end
    end

    // R04 two flops per cell
    for (int m = 0; m < NMC; m++) begin
      // R20 twelve sum terms
      sa = |term[term_of(m, pld_pkg::PT_SUM_A) +: pld_pkg::SUM_GRP];
      sb = |term[term_of(m, pld_pkg::PT_SUM_B) +: pld_pkg::SUM_GRP];
      sc = |term[term_of(m, pld_pkg::PT_SUM_C) +: pld_pkg::SUM_GRP];
      // R06 combined sum
      d1 = s_r.cfg[m][pld_pkg::CFG_COMBINE] ? (sa | sb | sc) : (sa | sb);
      d2 = sc;
      // R03 clock source select
      c1 = s_r.cfg[m][pld_pkg::CFG_MAIN_PCLK]
        ? s_r.ded_lvl[pld_pkg::PIN_CLK_IDX]
        : term[term_of(m, pld_pkg::PT_CK1)];
      c2 = s_r.cfg[m][pld_pkg::CFG_BUR_PCLK]
        ? s_r.ded_lvl[pld_pkg::PIN_CLK_IDX]
        : term[term_of(m, pld_pkg::PT_CK2)];
      s_nxt.main_ck_prev[m] = c1;
      s_nxt.buried_ck_prev[m] = c2;
      // R21 shared preset
      idx = pld_pkg::PRESET_BASE + preset_of(m);
      pre = term[idx];
      // R01 D or T, main flop; R23 preset on edge only
      if (c1 && !s_r.main_ck_prev[m]) begin
        if (pre) begin
          s_nxt.main_flop[m] = 1'b1;
        end else if (s_r.cfg[m][pld_pkg::CFG_MAIN_T]) begin
          s_nxt.main_flop[m] = s_r.main_flop[m] ^ d1;
        end else begin
          s_nxt.main_flop[m] = d1;
        end
      end
      // R01 D or T, buried flop
      if (c2 && !s_r.buried_ck_prev[m]) begin
        if (pre) begin
          s_nxt.buried_flop[m] = 1'b1;
        end else if (s_r.cfg[m][pld_pkg::CFG_BUR_T]) begin
          s_nxt.buried_flop[m] = s_r.buried_flop[m] ^ d2;
        end else begin
          s_nxt.buried_flop[m] = d2;
        end
      end
      // R23 clear beats clocking
      if (term[term_of(m, pld_pkg::PT_AR1)]) begin
        s_nxt.main_flop[m] = 1'b0;
      end
      if (term[term_of(m, pld_pkg::PT_AR2)]) begin
        s_nxt.buried_flop[m] = 1'b0;
      end
      // R02 bypass feeds next state back
      s_nxt.buried_feedback[m] = s_r.cfg[m][pld_pkg::CFG_BYPASS]
        ? d2 : s_r.buried_flop[m];
    end

    // R13 force load from pin, above all else
    s_nxt.strobe_prev = LOAD_STROBE;
    // R17 fuse blocks preload
    load_pulse = FORCE_LOAD_MODE && LOAD_STROBE && !s_r.strobe_prev
      && !s_r.secure;
    // R14 one group per strobe; R15 group select
    for (int m = 0; m < NMC; m++) begin
      if (load_pulse && (m % 2 == int'(EVEN_ODD_SELECT))) begin
        if (Q_SELECT) begin
          s_nxt.buried_flop[m] = IO_IN[m];
        end else begin
          s_nxt.main_flop[m] = IO_IN[m];
        end
      end
    end

    // Pin drive, taken from the updated flops
    for (int m = 0; m < NMC; m++) begin
      // R05 per-pin enable term
      s_nxt.io_oe[m] = term[term_of(m, pld_pkg::PT_OE)];
      // R16 observe buried; R17 fuse blocks it
      if (OBSERVE_MODE && !s_r.secure) begin
        s_nxt.io_out[m] = s_nxt.buried_flop[m];
      end else begin
        // R10 level follows polarity
        s_nxt.io_out[m] = s_r.cfg[m][pld_pkg::CFG_ACT_HIGH]
          ? s_nxt.main_flop[m] : ~s_nxt.main_flop[m];
      end
    end

    // APB: ready one cycle into the access phase
    s_nxt.pready = 1'b0;
    // Error is a one-cycle flag beside ready, never left standing
    s_nxt.pslverr = 1'b0;
    if (PSEL && PENABLE && !s_r.pready) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata = '0;
      if (fuse_hit) begin
        // R18 secured rows read as programmed
        if (s_r.secure) begin
          s_nxt.prdata = pld_pkg::SECURE_READ;
        end else begin
          s_nxt.prdata = fuse_mem[fuse_t][fuse_w*32 +: 32];
        end
      end else if (PADDR == pld_pkg::CTRL_ADDR) begin
        s_nxt.prdata[pld_pkg::CTRL_KEEPER] = s_r.keeper_en;
        s_nxt.prdata[pld_pkg::CTRL_SECURE] = s_r.secure;
      end else if (PADDR == pld_pkg::USER_LO_ADDR) begin
        s_nxt.prdata = s_r.user_row[31:0];
      end else if (PADDR == pld_pkg::USER_HI_ADDR) begin
        s_nxt.prdata = s_r.user_row[63:32];
      end else if (PADDR == pld_pkg::MAIN_STAT_ADDR) begin
        s_nxt.prdata[NMC-1:0] = s_r.main_flop;
      end else if (PADDR == pld_pkg::BUR_STAT_ADDR) begin
        s_nxt.prdata[NMC-1:0] = s_r.buried_flop;
      end else if (PADDR == pld_pkg::MODE_STAT_ADDR) begin
        s_nxt.prdata[0] = FORCE_LOAD_MODE && !s_r.secure;
        s_nxt.prdata[1] = OBSERVE_MODE && !s_r.secure;
      end else if (PADDR >= pld_pkg::CFG_BASE_ADDR
          && PADDR < pld_pkg::CFG_BASE_ADDR + 16'(4 * NMC)
          && PADDR[1:0] == 2'h0) begin
        idx = int'((PADDR - pld_pkg::CFG_BASE_ADDR) >> 2);
        s_nxt.prdata[pld_pkg::CFG_W-1:0] = s_r.cfg[idx];
      end else begin
        s_nxt.pslverr = 1'b1;
      end
    end

    // APB writes take effect at the completing edge
    if (acc_done && PWRITE) begin
      if (PADDR == pld_pkg::CTRL_ADDR) begin
        // R08 keeper only by software
        s_nxt.keeper_en = PWDATA[pld_pkg::CTRL_KEEPER];
        // Fuse is one-way: only a reset clears it
        s_nxt.secure = s_r.secure | PWDATA[pld_pkg::CTRL_SECURE];
      end else if (PADDR == pld_pkg::USER_LO_ADDR) begin
        // R09 user row
        s_nxt.user_row[31:0] = PWDATA;
      end else if (PADDR == pld_pkg::USER_HI_ADDR) begin
        s_nxt.user_row[63:32] = PWDATA;
      end else if (PADDR >= pld_pkg::CFG_BASE_ADDR
          && PADDR < pld_pkg::CFG_BASE_ADDR + 16'(4 * NMC)
          && PADDR[1:0] == 2'h0) begin
        idx = int'((PADDR - pld_pkg::CFG_BASE_ADDR) >> 2);
        s_nxt.cfg[idx] = PWDATA[pld_pkg::CFG_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // R10 all flops low at reset; R08 keepers off
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      s_r <= '0;
      for (int m = 0; m < NMC; m++) begin
        s_r.cfg[m] <= pld_pkg::CFG_RST;
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign PRDATA = s_r.prdata;
  assign PREADY = s_r.pready;
  assign PSLVERR = s_r.pslverr;
  assign IO_OUT = s_r.io_out;
  assign IO_OE = s_r.io_oe;

endmodule : pld_macrocell_array

// File: pld_pkg.sv
// Shared constants for the programmable macrocell array block
package pld_pkg;
  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int NUM_MC = 24;
  localparam int NUM_DED = 14;
  localparam int TERMS_PER_MC = 17;
  localparam int BUS_W = 172;
  localparam int NUM_PRESET = 8;
  localparam int NUM_TERMS = NUM_MC * TERMS_PER_MC + NUM_PRESET;
  localparam int PRESET_BASE = NUM_MC * TERMS_PER_MC;
  localparam int SUM_GRP = 4;
  localparam int FUSE_ROW_W = 192;
  localparam int USER_ROW_W = 64;
  // Product term slots inside one macrocell
  localparam int PT_SUM_A = 0;
  localparam int PT_SUM_B = 4;
  localparam int PT_SUM_C = 8;
  localparam int PT_AR1 = 12;
  localparam int PT_CK1 = 13;
  localparam int PT_CK2 = 14;
  localparam int PT_AR2 = 15;
  localparam int PT_OE = 16;
  // Global bus layout
  localparam int BUS_MC_BASE = 2 * NUM_DED;
  localparam int MC_BUS_W = 6;
  localparam int PIN_CLK_IDX = 0;
  // Preset sharing: four cells, then two, repeating
  localparam int PRESET_SPAN = 6;
  localparam int PRESET_FIRST = 4;
  // ----------------------------------------------------------------
  // Per-macrocell configuration word
  // ----------------------------------------------------------------
  localparam int CFG_W = 7;
  localparam int CFG_MAIN_T = 0;
  localparam int CFG_BUR_T = 1;
  localparam int CFG_MAIN_PCLK = 2;
  localparam int CFG_BUR_PCLK = 3;
  localparam int CFG_BYPASS = 4;
  localparam int CFG_COMBINE = 5;
  localparam int CFG_ACT_HIGH = 6;
  localparam logic [CFG_W-1:0] CFG_RST = 7'h00;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [15:0] FUSE_LIMIT = 16'h4000;
  localparam logic [15:0] CTRL_ADDR = 16'h4000;
  localparam logic [15:0] USER_LO_ADDR = 16'h4004;
  localparam logic [15:0] USER_HI_ADDR = 16'h4008;
  localparam logic [15:0] MAIN_STAT_ADDR = 16'h400c;
  localparam logic [15:0] BUR_STAT_ADDR = 16'h4010;
  localparam logic [15:0] MODE_STAT_ADDR = 16'h4014;
  localparam logic [15:0] CFG_BASE_ADDR = 16'h4100;
  localparam int FUSE_WORDS = 6;
  localparam int CTRL_KEEPER = 0;
  localparam int CTRL_SECURE = 1;
  localparam logic [31:0] SECURE_READ = 32'hffffffff;
endpackage : pld_pkg

// File: pld_monitor.sv
// Port checker for the macrocell array: bus handshake, reset, security
module pld_monitor #(
  parameter int ADDR_W = 16
) (
  input wire logic SYS_CLK, // Clock
  input wire logic SYS_RST, // Reset, high
  input wire logic [ADDR_W-1:0] PADDR, // Address
  input wire logic PSEL, // Select
  input wire logic PENABLE, // Access phase
  input wire logic PWRITE, // Write
  input wire logic [31:0] PWDATA, // Write data
  input wire logic [31:0] PRDATA, // Read data
  input wire logic PREADY, // Ready
  input wire logic PSLVERR, // Error
  input wire logic [pld_pkg::NUM_MC-1:0] IO_OUT, // Pin drive value
  input wire logic [pld_pkg::NUM_MC-1:0] IO_OE // Pin drive enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  logic secure_r;
  logic secure_nxt;
  // ----------------------------------------------------------------
  // Helper: security bit seen from completed CTRL writes
  // ----------------------------------------------------------------
  // Set only; a clear needs reset, as in the device
  always_comb begin
    secure_nxt = secure_r;
    if (PREADY && PWRITE && PADDR == pld_pkg::CTRL_ADDR
        && PWDATA[pld_pkg::CTRL_SECURE]) begin
      secure_nxt = 1'b1;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    secure_r <= SYS_RST ? 1'b0 : secure_nxt;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  ready_wait_a: assert property ($rose(PENABLE) && PSEL |=> PREADY)
    else $error("ready missing on second access cycle");
  early_ready_a: assert property ($rose(PENABLE) |-> !PREADY)
    else $error("ready in first access cycle");
  ready_phase_a: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access phase");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  unmapped_err_a: assert property (PREADY
    && PADDR > 16'h415c |-> PSLVERR)
    else $error("unmapped address not refused");
  fuse_write_a: assert property (PREADY && PWRITE
    && PADDR < pld_pkg::FUSE_LIMIT |-> !PSLVERR)
    else $error("fuse write refused");
  secure_read_a: assert property (PREADY && !PWRITE && secure_r
    && PADDR < pld_pkg::FUSE_LIMIT |-> PRDATA == pld_pkg::SECURE_READ)
    else $error("secured fuse row readable");
  secure_mode_a: assert property (PREADY && !PWRITE && secure_r
    && PADDR == pld_pkg::MODE_STAT_ADDR |-> PRDATA[1:0] == 2'b00)
    else $error("test mode active while secured");
  reset_out_a: assert property ($fell(SYS_RST) |-> IO_OE == '0
    && IO_OUT == '0 && !PREADY)
    else $error("outputs not cleared by reset");
  oe_empty_a: assert property ($fell(SYS_RST) |-> ##3 IO_OE == '1)
    else $error("empty enable term not driving");
endmodule : pld_monitor

// File: board_model.sv
// Board-side model driving the dedicated inputs and I/O pin levels
module board_model (
  input wire logic clk, // System clock
  input wire logic rst, // Reset, high
  input wire logic pin_clk_req, // Bench asks for pin clock high
  input wire logic io_drive, // Board drives the I/O pins
  input wire logic [23:0] io_pat, // Level the board drives
  output logic [13:0] ded_in, // Dedicated input levels
  output logic [13:0] ded_driven, // Dedicated drive flags
  output logic [23:0] io_in, // I/O levels seen
  output logic [23:0] io_driven // I/O drive flags
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk_r = 1'b0;
  logic [23:0] last_r = '0;
  // pin clock held
  // Still during reset, low until the bench asks after setup
  always @(posedge clk) begin
    if (rst) begin
      pclk_r <= 1'b0;
    end else begin
      pclk_r <= pin_clk_req;
    end
    if (io_drive) begin
      last_r <= io_pat;
    end
  end
  // Released pins show inverse of last level so stale data never passes
  assign io_in = io_drive ? io_pat : ~last_r;
  assign io_driven = {24{io_drive}};
  assign ded_in = {13'h0, pclk_r};
  assign ded_driven = '1;
endmodule : board_model

// File: tb_top.sv
// Testbench for the macrocell array through its register bus and pins
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rst = 1'b1;
  logic [15:0] paddr = '0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr;
  wire logic [13:0] ded_in, ded_driven;
  wire logic [23:0] io_in, io_driven, io_out, io_oe;
  logic fl_mode = 1'b0, strobe = 1'b0, qsel = 1'b0, eosel = 1'b0;
  logic obs = 1'b0, pclk_req = 1'b0, io_drive = 1'b1;
  logic [23:0] io_pat = '0, main_exp = '0, bur_exp = '0, mask, pat;
  logic [31:0] rdata;
  logic err;
  int fail_count = 0, comparisons = 0, cyc = 0;
  pld_macrocell_array uut (.SYS_CLK(clk), .SYS_RST(rst), .PADDR(paddr),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .DED_IN(ded_in), .DED_DRIVEN(ded_driven), .IO_IN(io_in),
    .IO_DRIVEN(io_driven), .IO_OUT(io_out), .IO_OE(io_oe),
    .FORCE_LOAD_MODE(fl_mode), .LOAD_STROBE(strobe), .Q_SELECT(qsel),
    .EVEN_ODD_SELECT(eosel), .OBSERVE_MODE(obs));
  board_model board (.clk(clk), .rst(rst), .pin_clk_req(pclk_req),
    .io_drive(io_drive), .io_pat(io_pat), .ded_in(ded_in),
    .ded_driven(ded_driven), .io_in(io_in), .io_driven(io_driven));
  // ----------------------------------------------------------------
  // Clock, timeout and bus tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Ceiling well above the roughly 700 cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Request held until ready is sampled high, then an idle cycle
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rdc(input string nm, input logic [15:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdata);
  endtask : rdc
  function automatic logic [15:0] fa(input int t);
    return 16'(t * 32);
  endfunction : fa
  task automatic pulse(input logic [23:0] p);
    io_pat <= p;
    repeat (2) @(posedge clk);
    strobe <= 1'b1;
    repeat (2) @(posedge clk);
    strobe <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc("ctrl", pld_pkg::CTRL_ADDR, 32'h0);
    rdc("user_hi", pld_pkg::USER_HI_ADDR, 32'h0);
    rdc("cfg0", pld_pkg::CFG_BASE_ADDR, 32'h0);
    apb(1'b0, 16'h4200, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    chk("oe", 32'h00ffffff, 32'(io_oe));
    // clears, clocks and presets held off
    for (int m = 0; m < 24; m++) begin
      for (int k = 12; k < 16; k++) apb(1'b1, fa(m * 17 + k), 32'hc);
    end
    for (int p = 408; p < 416; p++) apb(1'b1, fa(p), 32'hc);
    rdc("fuse", fa(12), 32'hc);
    // pin clock main flops, cell 0 toggle type
    for (int m = 0; m < 24; m++) begin
      apb(1'b1, pld_pkg::CFG_BASE_ADDR + 16'(4 * m),
          m == 0 ? 32'h45 : 32'h44);
    end
    fl_mode <= 1'b1;
    for (int g = 0; g < 4; g++) begin
      qsel <= g[0];
      eosel <= g[1];
      pat = 24'ha5c396 ^ (24'h00ffff << (4 * g));
      mask = g[1] ? 24'haaaaaa : 24'h555555;
      if (g[0]) bur_exp = (bur_exp & ~mask) | (pat & mask);
      else main_exp = (main_exp & ~mask) | (pat & mask);
      pulse(pat);
    end
    rdc("mode", pld_pkg::MODE_STAT_ADDR, 32'h1);
    fl_mode <= 1'b0;
    rdc("main", pld_pkg::MAIN_STAT_ADDR, 32'(main_exp));
    rdc("bur", pld_pkg::BUR_STAT_ADDR, 32'(bur_exp));
    obs <= 1'b1;
    repeat (4) @(posedge clk);
    chk("obs_out", 32'(bur_exp), 32'(io_out));
    obs <= 1'b0;
    repeat (4) @(posedge clk);
    chk("io_out", 32'(main_exp), 32'(io_out));
    // one pin clock edge: D cells load 1, cell 0 toggles
    pclk_req <= 1'b1;
    repeat (4) @(posedge clk);
    pclk_req <= 1'b0;
    repeat (4) @(posedge clk);
    main_exp = {23'h7fffff, ~main_exp[0]};
    rdc("main_clk", pld_pkg::MAIN_STAT_ADDR, 32'(main_exp));
    rdc("bur_clk", pld_pkg::BUR_STAT_ADDR, 32'(bur_exp));
    // empty clear term on cell 1 clears at once
    apb(1'b1, fa(29), 32'h0);
    main_exp[1] = 1'b0;
    rdc("main_clr", pld_pkg::MAIN_STAT_ADDR, 32'(main_exp));
    apb(1'b1, pld_pkg::USER_LO_ADDR, 32'h13572468);
    apb(1'b1, pld_pkg::USER_HI_ADDR, 32'h9abcdef0);
    rdc("user_lo", pld_pkg::USER_LO_ADDR, 32'h13572468);
    rdc("user_hi", pld_pkg::USER_HI_ADDR, 32'h9abcdef0);
    rdc("main_usr", pld_pkg::MAIN_STAT_ADDR, 32'(main_exp));
    apb(1'b1, pld_pkg::CTRL_ADDR, 32'h1);
    rdc("keeper", pld_pkg::CTRL_ADDR, 32'h1);
    // cell 4 pin released, keeper must hold it for the buried flop
    apb(1'b1, fa(76) + 16'h4, 32'h01000000);
    for (int k = 77; k < 80; k++) apb(1'b1, fa(k), 32'hc);
    apb(1'b1, fa(84), 32'hc);
    apb(1'b1, pld_pkg::CFG_BASE_ADDR + 16'h10, 32'h4c);
    io_pat <= 24'h000010;
    repeat (2) @(posedge clk);
    io_drive <= 1'b0;
    repeat (2) @(posedge clk);
    pclk_req <= 1'b1;
    repeat (4) @(posedge clk);
    pclk_req <= 1'b0;
    repeat (4) @(posedge clk);
    main_exp[0] = ~main_exp[0];
    bur_exp[4] = 1'b1;
    rdc("keep_bur", pld_pkg::BUR_STAT_ADDR, 32'(bur_exp));
    rdc("keep_main", pld_pkg::MAIN_STAT_ADDR, 32'(main_exp));
    chk("oe_off", 32'h00ffffef, 32'(io_oe));
    // security blocks readback, preload and observe
    apb(1'b1, pld_pkg::CTRL_ADDR, 32'h3);
    rdc("fuse_sec", fa(12), pld_pkg::SECURE_READ);
    fl_mode <= 1'b1;
    obs <= 1'b1;
    pulse(~main_exp);
    rdc("mode_sec", pld_pkg::MODE_STAT_ADDR, 32'h0);
    rdc("main_sec", pld_pkg::MAIN_STAT_ADDR, 32'(main_exp));
    finish_test();
  end
endmodule : tb_top
bind pld_macrocell_array pld_monitor #(.ADDR_W(ADDR_W)) mon (
  .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .PADDR(PADDR), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .IO_OUT(IO_OUT), .IO_OE(IO_OE));
